/* File: rtl/parallel_command_shutter_ctrl.sv */
/*
 Parallel command input with shutter handling: one byte in, busy out,
 positioner target out. Assumes data lines synchronous to clk and a
 host that waits for busy low before sending the next byte.
*/
// Functional notes
// - The input byte is taken either as a filter position or as a command code.
// - Busy is the only status returned to the host.
// - Position 0 sets the positioners to block the light path.
// - Any nonzero position moves the positioners there, opening the light path.
// - Close saves the current position and then moves to position 0.
// - Restore moves back to the position saved by the latest close.
// - A byte present while busy is high is not executed until busy falls.
// - The low four bits carry position or command bits, the high four command bits only.
`timescale 1ns/1ps
module parallel_command_shutter_ctrl #(
  parameter int SETTLE_CYCLES = shutter_pkg::SETTLE_CYC
)(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [shutter_pkg::DATA_W-1:0] cmd_data,
  output logic busy,
  output logic [shutter_pkg::POS_W-1:0] target_pos,
  output logic light_blocked
);
  typedef struct packed {
    logic [7:0] last_byte;
    logic [3:0] pos;
    logic [3:0] saved;
    logic blocked;
    logic primed;
  } ctrl_s;
  ctrl_s st_r;
  ctrl_s st_nxt;
  logic start;
  logic settling;
  logic is_pos;

  if (shutter_pkg::DATA_W != 8 || shutter_pkg::POS_W != 4)
  begin
    $error("parallel_command_shutter_ctrl: widths unsupported");
  end

  // Busy must stand two cycles or a fast host could miss its rise
  if (SETTLE_CYCLES < 2)
  begin
    $error("parallel_command_shutter_ctrl: SETTLE_CYCLES below two");
  end

  ////////////////////////////////////////////////////////////////////////
  settle_timer #(.CYCLES(SETTLE_CYCLES)) u_timer (
    .clk(clk),
    .reset_n(reset_n),
    .start(start),
    .running(settling)
  );

  ////////////////////////////////////////////////////////////////////////
  // position decode
  // Upper nibble nonzero means a command, never a position
  assign is_pos = (cmd_data[7:4] == 4'h0);

  always_comb
  begin
    st_nxt = st_r;
    start = 1'b0;
    // hold off while busy
    // Only a changed byte is a new command, so a held level is not re-run
    if (!settling && st_r.primed && cmd_data != st_r.last_byte)
    begin
      st_nxt.last_byte = cmd_data;
      if (is_pos)
      begin
        st_nxt.pos = cmd_data[3:0];
        st_nxt.blocked = (cmd_data[3:0] == shutter_pkg::POS_BLOCKED);
        start = 1'b1;
      end
      else if (cmd_data == shutter_pkg::CMD_CLOSE)
      begin
        st_nxt.saved = st_r.pos;
        st_nxt.pos = shutter_pkg::POS_BLOCKED;
        st_nxt.blocked = 1'b1;
        start = 1'b1;
      end
      else if (cmd_data == shutter_pkg::CMD_RESTORE)
      begin
        st_nxt.pos = st_r.saved;
        st_nxt.blocked = (st_r.saved == shutter_pkg::POS_BLOCKED);
        start = 1'b1;
      end
    end
    if (!st_r.primed)
    begin
      // Byte on the lines at reset is not taken as a command
      st_nxt.primed = 1'b1;
      st_nxt.last_byte = cmd_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      st_r <= '{last_byte: 8'h00, pos: shutter_pkg::POS_RESET, saved: shutter_pkg::POS_RESET,
                blocked: 1'b1, primed: 1'b0};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // single status output
  assign busy = settling;
  assign target_pos = st_r.pos;
  assign light_blocked = st_r.blocked;

  ////////////////////////////////////////////////////////////////////////
  // A byte that is due to be taken at this edge
  sequence s_fresh;
    !settling && st_r.primed && cmd_data != st_r.last_byte;
  endsequence

  sequence s_close;
    start && cmd_data == shutter_pkg::CMD_CLOSE;
  endsequence

  sequence s_restore;
    start && cmd_data == shutter_pkg::CMD_RESTORE;
  endsequence

  sequence s_move_nonzero;
    start && is_pos && cmd_data[3:0] != 4'h0;
  endsequence

  a_close_saves: assert property (@(posedge clk) disable iff (!reset_n)
    s_close |=> target_pos == 4'h0 && light_blocked && st_r.saved == $past(target_pos))
    else $error("close did not save and block");

  a_restore_moves: assert property (@(posedge clk) disable iff (!reset_n)
    s_restore |=> target_pos == $past(st_r.saved))
    else $error("restore did not return to saved position");

  a_zero_blocks: assert property (@(posedge clk) disable iff (!reset_n)
    start && cmd_data == 8'h00 |=> light_blocked && target_pos == 4'h0)
    else $error("position zero not blocked");

  a_blocked_tracks: assert property (@(posedge clk) disable iff (!reset_n)
    light_blocked == (target_pos == shutter_pkg::POS_BLOCKED))
    else $error("blocked flag disagrees with target");

  a_nonzero_opens: assert property (@(posedge clk) disable iff (!reset_n)
    s_move_nonzero |=> !light_blocked && target_pos == $past(cmd_data[3:0]))
    else $error("nonzero position not taken");

  a_busy_rises: assert property (@(posedge clk) disable iff (!reset_n)
    start |=> busy [*2])
    else $error("busy not raised on accepted move");

  a_busy_ends: assert property (@(posedge clk) disable iff (!reset_n)
    start |=> ##[1:SETTLE_CYCLES] !busy)
    else $error("busy did not fall after settling");

  a_busy_cause: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(busy) |-> $past(start))
    else $error("busy rose without an accepted move");

  a_busy_holds: assert property (@(posedge clk) disable iff (!reset_n)
    busy |=> $stable(target_pos) || !$past(busy))
    else $error("command executed while busy");

  a_busy_refuses: assert property (@(posedge clk) disable iff (!reset_n)
    settling |-> !start)
    else $error("byte taken while settling");

  a_idle_quiet: assert property (@(posedge clk) disable iff (!reset_n)
    !start |=> $stable(target_pos) && $stable(light_blocked))
    else $error("target changed without a taken byte");

  a_upper_cmd: assert property (@(posedge clk) disable iff (!reset_n)
    start && cmd_data[7:4] != 4'h0 |-> cmd_data == 8'haa || cmd_data == 8'hac)
    else $error("upper nibble taken as position");

  a_unknown_idle: assert property (@(posedge clk) disable iff (!reset_n)
    s_fresh ##0 (!is_pos && cmd_data != shutter_pkg::CMD_CLOSE
      && cmd_data != shutter_pkg::CMD_RESTORE) |-> !start)
    else $error("unknown code started a move");

  a_byte_decode: assert property (@(posedge clk) disable iff (!reset_n)
    s_fresh ##0 is_pos |-> start)
    else $error("position byte not interpreted");

  a_cmd_decode: assert property (@(posedge clk) disable iff (!reset_n)
    s_fresh ##0 (cmd_data == shutter_pkg::CMD_CLOSE || cmd_data == shutter_pkg::CMD_RESTORE) |-> start)
    else $error("shutter command not interpreted");

  a_repeat_ignored: assert property (@(posedge clk) disable iff (!reset_n)
    st_r.primed && cmd_data == st_r.last_byte |-> !start)
    else $error("repeated byte executed again");
endmodule

/* File: rtl/settle_timer.sv */
/*
 Settle timer: counts down a fixed number of cycles after a start pulse.
 Assumes a start pulse only while idle.
*/
`timescale 1ns/1ps
module settle_timer #(
  parameter int CYCLES = shutter_pkg::SETTLE_CYC
)(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic start,
  output logic running
);
  typedef struct packed {
    logic [shutter_pkg::SETTLE_W-1:0] cnt;
  } timer_s;
  timer_s st_r;
  timer_s st_nxt;

  // Count must fit the counter and be at least one cycle
  if (CYCLES < 1 || CYCLES >= (1 << shutter_pkg::SETTLE_W))
  begin
    $error("settle_timer: CYCLES out of range");
  end

  always_comb
  begin
    st_nxt = st_r;
    if (start)
    begin
      st_nxt.cnt = shutter_pkg::SETTLE_W'(CYCLES);
    end
    else if (st_r.cnt != '0)
    begin
      st_nxt.cnt = st_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign running = (st_r.cnt != '0);
endmodule

/* File: rtl/shutter_pkg.sv */
/*
 Constants shared by the parallel command input and its settle timer.
 Assumes a 40 MHz core clock.
*/
package shutter_pkg;
  localparam int CLK_MHZ = 40;
  localparam int DATA_W = 8;
  localparam int POS_W = 4;
  localparam logic [7:0] CMD_RESTORE = 8'haa;
  localparam logic [7:0] CMD_CLOSE = 8'hac;
  localparam logic [3:0] POS_BLOCKED = 4'h0;
  localparam logic [3:0] POS_RESET = 4'h0;
  localparam int SETTLE_US = 2;
  localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
  localparam int SETTLE_W = 16;
endpackage

/* File: test/host_port_model.sv */
/*
 Host printer port model: drives the command byte, reads busy back.
 Assumes the device samples cmd_data on rising clk edges.
*/
`timescale 1ns/1ps
module host_port_model (
  input wire logic clk,
  input wire logic busy,
  output logic [7:0] cmd_data
);
  logic [7:0] status_in;
  assign status_in = {~busy, 7'h7f};
  initial cmd_data = 8'h00;
  task automatic put(input logic [7:0] b);
    @(posedge clk);
    #2 cmd_data = b;
  endtask
  // wait busy high, then poll mask 128 until ready
  task automatic send(input logic [7:0] b, output int hi);
    int n;
    n = 0;
    hi = 0;
    put(b);
    while ((status_in & 8'h80) == 8'h80 && n < 20)
    begin
      @(posedge clk);
      #1 n++;
    end
    while ((status_in & 8'h80) != 8'h80 && hi < 500)
    begin
      @(posedge clk);
      #1 hi++;
    end
  endtask
endmodule

/* File: test/parallel_command_shutter_ctrl_test.sv */
/*
 Testbench for the parallel command input with shutter handling.
 Assumes a short settle count; the host model owns cmd_data.
*/
`timescale 1ns/1ps
module parallel_command_shutter_ctrl_test;
  localparam int SC = 3;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic busy;
  logic [3:0] target_pos;
  logic light_blocked;
  logic [7:0] cmd_data;
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;
  int hi;
  always #12.5 clk = ~clk;
  parallel_command_shutter_ctrl #(.SETTLE_CYCLES(SC)) i_dut (.clk(clk), .reset_n(reset_n),
    .cmd_data(cmd_data), .busy(busy), .target_pos(target_pos), .light_blocked(light_blocked));
  host_port_model i_host (.clk(clk), .busy(busy), .cmd_data(cmd_data));
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Hang guard, far above the hundred or so cycles needed
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fail_count++;
      report_and_stop();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic move_open;
    i_host.send(8'h03, hi);
    check("busy len", 8'(hi), 8'(SC));
    check("target", 8'(target_pos), 8'h03);
    check("blocked", 8'(light_blocked), 8'h00);
  endtask
  task automatic shutter_pair;
    i_host.send(8'hac, hi);
    check("close tgt", 8'(target_pos), 8'h00);
    check("close blk", 8'(light_blocked), 8'h01);
    i_host.send(8'haa, hi);
    check("open tgt", 8'(target_pos), 8'h03);
    check("open blk", 8'(light_blocked), 8'h00);
  endtask
  task automatic busy_refused;
    i_host.put(8'h05);
    i_host.put(8'h06);
    check("held", 8'(target_pos), 8'h05);
    repeat (SC + 3) @(posedge clk);
    #3 check("late", 8'(target_pos), 8'h06);
    repeat (SC + 2) @(posedge clk);
  endtask
  task automatic unknown_ignored;
    i_host.put(8'h55);
    repeat (2) @(posedge clk);
    #3 check("unk busy", 8'(busy), 8'h00);
    check("unk tgt", 8'(target_pos), 8'h06);
  endtask
  task automatic zero_and_latest;
    i_host.send(8'h00, hi);
    check("zero len", 8'(hi), 8'(SC));
    check("zero tgt", 8'(target_pos), 8'h00);
    check("zero blk", 8'(light_blocked), 8'h01);
    i_host.send(8'h09, hi);
    check("nine tgt", 8'(target_pos), 8'h09);
    i_host.send(8'hac, hi);
    i_host.send(8'h02, hi);
    i_host.send(8'hac, hi);
    check("second blk", 8'(light_blocked), 8'h01);
    i_host.send(8'haa, hi);
    check("latest tgt", 8'(target_pos), 8'h02);
    check("latest blk", 8'(light_blocked), 8'h00);
  endtask
  // Byte held across reset is only a baseline, and the saved slot is cleared
  task automatic reset_again;
    @(posedge clk);
    #2 reset_n = 1'b0;
    repeat (2) @(posedge clk);
    #2 reset_n = 1'b1;
    repeat (2) @(posedge clk);
    #3 check("re busy", 8'(busy), 8'h00);
    check("re tgt", 8'(target_pos), 8'h00);
    check("re blk", 8'(light_blocked), 8'h01);
    i_host.send(8'h01, hi);
    check("re pos", 8'(target_pos), 8'h01);
    i_host.send(8'haa, hi);
    check("re open", 8'(target_pos), 8'h00);
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    #2 reset_n = 1'b1;
    repeat (2) @(posedge clk);
    #3 check("rst busy", 8'(busy), 8'h00);
    check("rst blk", 8'(light_blocked), 8'h01);
    move_open();
    shutter_pair();
    busy_refused();
    unknown_ignored();
    zero_and_latest();
    reset_again();
    report_and_stop();
  end
endmodule
